/* rftx_driver_config.sv */
// Transmitter driver configuration register bank and driver pin control.
//
// Contract
// R1: Mode bit 7 inverts driver pin two.
// R2: Mode bit 6 inverts driver pin one.
// R3: Mode bit 3 enables both driver pins.
// R4: Mode bits 2:0 select output drive style.
// R5: Software never writes style codes 011, 110.
// R6: Amplitude bits 7:6 pick supply drop level.
// R7: Amplitude bits 4:0 set residual carrier percentage.
// R8: Full-level bit overrides the drop field.
// R9: Control bits 7:4 give overshoot carrier clocks.
// R10: Control bit 2 inverts selected modulation.
// R11: Control bits 1:0 choose modulation source.
// R12: Reserved bits read zero, ignore writes.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module rftx_driver_config
  import rftx_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic carrier_tick,
  input wire logic internal_envelope,
  input wire logic external_signal_input,
  output logic driver_pin_one_out,
  output logic driver_pin_one_oe_n,
  output logic driver_pin_two_out,
  output logic driver_pin_two_oe_n,
  output logic [9:0] carrier_level_drop_mv,
  output logic carrier_full_level,
  output logic [4:0] residual_carrier,
  output logic modulation_active
);

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] amp;
    logic [7:0] ctl;
    logic [7:0] rdata;
    rftx_pin_t pin_one;
    rftx_pin_t pin_two;
    logic [9:0] drop_mv;
    logic full;
    logic [4:0] residual;
    logic mod;
  } rftx_state_t;

  rftx_state_t s_r;
  rftx_state_t s_nxt;
  rftx_bus_t bus;
  logic mod_sel;
  logic mod_stretched;
  rftx_style_t style;
  rftx_src_t src;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign style = rftx_style_t'(s_r.mode[2:0]);
  assign src = rftx_src_t'(s_r.ctl[1:0]);

  // =====================================================================
  // Modulation source selection
  always_comb begin
    unique case (src)
      RFTX_SRC_NONE: mod_sel = 1'b0; // see R11
      RFTX_SRC_ENVELOPE: mod_sel = internal_envelope; // see R11
      RFTX_SRC_EXTERNAL: mod_sel = external_signal_input; // see R11
      RFTX_SRC_RESERVED: mod_sel = 1'b0;
    endcase
  end

  rftx_overshoot #(
    .LEN_W(4)
  ) u_overshoot (
    .clock(clock),
    .rst(rst),
    .carrier_tick(carrier_tick),
    .mod_in(mod_sel),
    .overshoot_length(s_r.ctl[7:4]),
    .mod_out(mod_stretched)
  );

  // =====================================================================
  // Next state: register writes, read data and pin drive
  // Unsupported style codes fall back to high impedance, so a software slip
  // cannot fight the antenna network.
  always_comb begin
    logic carrier;
    rftx_pin_t p1;
    rftx_pin_t p2;
    carrier = 1'b0;
    p1 = '{level: 1'b0, oe_n: 1'b1};
    p2 = '{level: 1'b0, oe_n: 1'b1};
    s_nxt = s_r;
    if (bus.wr) begin
      unique case (bus.addr)
        RFTX_ADDR_DRIVER_MODE: s_nxt.mode = bus.wdata & RFTX_MASK_DRIVER_MODE; // see R12
        RFTX_ADDR_AMPLITUDE: s_nxt.amp = bus.wdata & RFTX_MASK_AMPLITUDE; // see R12
        RFTX_ADDR_MODULATION: s_nxt.ctl = bus.wdata & RFTX_MASK_MODULATION;
        default: ;
      endcase
    end
    s_nxt.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        RFTX_ADDR_DRIVER_MODE: s_nxt.rdata = s_r.mode;
        RFTX_ADDR_AMPLITUDE: s_nxt.rdata = s_r.amp;
        RFTX_ADDR_MODULATION: s_nxt.rdata = s_r.ctl;
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    carrier = mod_stretched ^ s_r.ctl[RFTX_BIT_MOD_INVERT]; // see R10
    s_nxt.mod = carrier;
    if (s_r.mode[RFTX_BIT_DRIVERS_ON]) begin // see R3
      unique case (style) // see R4
        RFTX_STY_OPEN_DRAIN: begin
          p1 = '{level: 1'b0, oe_n: carrier ^ s_r.mode[RFTX_BIT_INV_ONE]};
          p2 = '{level: 1'b0, oe_n: carrier ^ s_r.mode[RFTX_BIT_INV_TWO]};
        end
        RFTX_STY_PUSH_PULL: begin
          p1 = '{level: carrier ^ s_r.mode[RFTX_BIT_INV_ONE], oe_n: 1'b0}; // see R2
          p2 = '{level: carrier ^ s_r.mode[RFTX_BIT_INV_TWO], oe_n: 1'b0}; // see R1
        end
        RFTX_STY_FORCE_HIGH: begin
          p1 = '{level: 1'b1, oe_n: 1'b0};
          p2 = '{level: 1'b1, oe_n: 1'b0};
        end
        RFTX_STY_FORCE_LOW: begin
          p1 = '{level: 1'b0, oe_n: 1'b0};
          p2 = '{level: 1'b0, oe_n: 1'b0};
        end
        default: begin
          p1 = '{level: 1'b0, oe_n: 1'b1}; // see R5
          p2 = '{level: 1'b0, oe_n: 1'b1};
        end
      endcase
    end
    s_nxt.pin_one = p1;
    s_nxt.pin_two = p2;
    s_nxt.full = s_r.ctl[RFTX_BIT_FULL_LEVEL];
    if (s_r.ctl[RFTX_BIT_FULL_LEVEL]) begin
      s_nxt.drop_mv = RFTX_DROP_MV_NONE; // see R8
    end else begin
      unique case (s_r.amp[7:6]) // see R6
        2'b00: s_nxt.drop_mv = RFTX_DROP_MV_0;
        2'b01: s_nxt.drop_mv = RFTX_DROP_MV_1;
        2'b10: s_nxt.drop_mv = RFTX_DROP_MV_2;
        2'b11: s_nxt.drop_mv = RFTX_DROP_MV_3;
      endcase
    end
    s_nxt.residual = s_r.amp[4:0]; // see R7
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '{mode: RFTX_RST_DRIVER_MODE, amp: RFTX_RST_AMPLITUDE, ctl: RFTX_RST_MODULATION,
               rdata: 8'h00, pin_one: '{level: 1'b0, oe_n: 1'b1}, pin_two: '{level: 1'b0, oe_n: 1'b1},
               drop_mv: RFTX_DROP_MV_0, full: 1'b0, residual: 5'h00, mod: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign driver_pin_one_out = s_r.pin_one.level;
  assign driver_pin_one_oe_n = s_r.pin_one.oe_n;
  assign driver_pin_two_out = s_r.pin_two.level;
  assign driver_pin_two_oe_n = s_r.pin_two.oe_n;
  assign carrier_level_drop_mv = s_r.drop_mv;
  assign carrier_full_level = s_r.full;
  assign residual_carrier = s_r.residual;
  assign modulation_active = s_r.mod;

  // =====================================================================
  // Checks
  property p_inv_two;
    @(posedge clock) disable iff (rst)
      (s_r.mode[3] && s_r.mode[2:0] == 3'b001) |=> (driver_pin_two_out == (modulation_active ^ $past(s_r.mode[7])));
  endproperty
  a_inv_two: assert property (p_inv_two) else $error("pin two level mismatch"); // see R1

  property p_inv_one;
    @(posedge clock) disable iff (rst)
      (s_r.mode[3] && s_r.mode[2:0] == 3'b001) |=> (driver_pin_one_out == (modulation_active ^ $past(s_r.mode[6])));
  endproperty
  a_inv_one: assert property (p_inv_one) else $error("pin one level mismatch"); // see R2

  property p_off;
    @(posedge clock) disable iff (rst)
      !s_r.mode[3] |=> (driver_pin_one_oe_n && driver_pin_two_oe_n);
  endproperty
  a_off: assert property (p_off) else $error("pins driven while disabled"); // see R3

  property p_force_high;
    @(posedge clock) disable iff (rst)
      (s_r.mode[3] && s_r.mode[2:0] == 3'b100) |=> (driver_pin_one_out && !driver_pin_one_oe_n && driver_pin_two_out);
  endproperty
  a_force_high: assert property (p_force_high) else $error("force high not driven"); // see R4

  property p_bad_style;
    @(posedge clock) disable iff (rst)
      (s_r.mode[2:0] == 3'b011 || s_r.mode[2:0] == 3'b110) |=> (driver_pin_one_oe_n && driver_pin_two_oe_n);
  endproperty
  a_bad_style: assert property (p_bad_style) else $error("unsupported style drives pins"); // see R5

  property p_drop;
    @(posedge clock) disable iff (rst)
      (!s_r.ctl[3] && s_r.amp[7:6] == 2'b11) |=> (carrier_level_drop_mv == RFTX_DROP_MV_3);
  endproperty
  a_drop: assert property (p_drop) else $error("drop level wrong"); // see R6

  property p_residual;
    @(posedge clock) disable iff (rst)
      (wr && addr == RFTX_ADDR_AMPLITUDE) |=> ##1 (residual_carrier == $past(wdata[4:0], 2));
  endproperty
  a_residual: assert property (p_residual) else $error("residual carrier not applied"); // see R7

  property p_full;
    @(posedge clock) disable iff (rst)
      s_r.ctl[3] |=> (carrier_level_drop_mv == RFTX_DROP_MV_NONE && carrier_full_level);
  endproperty
  a_full: assert property (p_full) else $error("full level ignored"); // see R8

  property p_src_none;
    @(posedge clock) disable iff (rst)
      (s_r.ctl[1:0] == 2'b00 && s_r.ctl[7:4] == 4'h0 && !mod_stretched) |=> (modulation_active == $past(s_r.ctl[2]));
  endproperty
  a_src_none: assert property (p_src_none) else $error("no-modulation source not idle"); // see R11

  property p_invert;
    @(posedge clock) disable iff (rst)
      1'b1 |=> (modulation_active == ($past(mod_stretched) ^ $past(s_r.ctl[2])));
  endproperty
  a_invert: assert property (p_invert) else $error("modulation invert wrong"); // see R10

  property p_reserved;
    @(posedge clock) disable iff (rst)
      (rd && addr == RFTX_ADDR_DRIVER_MODE) |=> (rdata[5:4] == 2'b00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero"); // see R12

  property p_stretch;
    @(posedge clock) disable iff (rst)
      ($fell(mod_sel) && s_r.ctl[7:4] != 4'h0) |=> mod_stretched;
  endproperty
  a_stretch: assert property (p_stretch) else $error("overshoot stretch missing"); // see R9

  // =====================================================================
  // Checks on drive styles, levels, sources and stored fields
  property p_od_two;
    @(posedge clock) disable iff (rst)
      (s_r.mode[3] && s_r.mode[2:0] == 3'b000) |=>
        (!driver_pin_two_out && driver_pin_two_oe_n == (modulation_active ^ $past(s_r.mode[7])));
  endproperty
  a_od_two: assert property (p_od_two) else $error("open drain pin two wrong"); // see R1

  property p_od_one;
    @(posedge clock) disable iff (rst)
      (s_r.mode[3] && s_r.mode[2:0] == 3'b000) |=>
        (!driver_pin_one_out && driver_pin_one_oe_n == (modulation_active ^ $past(s_r.mode[6])));
  endproperty
  a_od_one: assert property (p_od_one) else $error("open drain pin one wrong"); // see R2

  property p_force_low;
    @(posedge clock) disable iff (rst)
      (s_r.mode[3] && s_r.mode[2:0] == 3'b101) |=>
        (!driver_pin_one_out && !driver_pin_one_oe_n && !driver_pin_two_out && !driver_pin_two_oe_n);
  endproperty
  a_force_low: assert property (p_force_low) else $error("force low not driven"); // see R4

  property p_high_z;
    @(posedge clock) disable iff (rst)
      (s_r.mode[2:0] == 3'b010) |=> (driver_pin_one_oe_n && driver_pin_two_oe_n);
  endproperty
  a_high_z: assert property (p_high_z) else $error("high impedance style drives pins"); // see R4

  property p_off_level;
    @(posedge clock) disable iff (rst)
      !s_r.mode[3] |=> (!driver_pin_one_out && !driver_pin_two_out);
  endproperty
  a_off_level: assert property (p_off_level) else $error("disabled pins show a level"); // see R3

  property p_on_drives;
    @(posedge clock) disable iff (rst)
      (s_r.mode[3] && s_r.mode[2:0] == 3'b001) |=> (!driver_pin_one_oe_n && !driver_pin_two_oe_n);
  endproperty
  a_on_drives: assert property (p_on_drives) else $error("enabled pins not driven"); // see R3

  property p_drop_0;
    @(posedge clock) disable iff (rst)
      (!s_r.ctl[3] && s_r.amp[7:6] == 2'b00) |=> (carrier_level_drop_mv == RFTX_DROP_MV_0);
  endproperty
  a_drop_0: assert property (p_drop_0) else $error("drop level code 0 wrong"); // see R6

  property p_drop_1;
    @(posedge clock) disable iff (rst)
      (!s_r.ctl[3] && s_r.amp[7:6] == 2'b01) |=> (carrier_level_drop_mv == RFTX_DROP_MV_1);
  endproperty
  a_drop_1: assert property (p_drop_1) else $error("drop level code 1 wrong"); // see R6

  property p_drop_2;
    @(posedge clock) disable iff (rst)
      (!s_r.ctl[3] && s_r.amp[7:6] == 2'b10) |=> (carrier_level_drop_mv == RFTX_DROP_MV_2);
  endproperty
  a_drop_2: assert property (p_drop_2) else $error("drop level code 2 wrong"); // see R6

  property p_full_off;
    @(posedge clock) disable iff (rst)
      !s_r.ctl[3] |=> !carrier_full_level;
  endproperty
  a_full_off: assert property (p_full_off) else $error("full level shown while off"); // see R8

  property p_src_env;
    @(posedge clock) disable iff (rst)
      (s_r.ctl[1:0] == 2'b01 && s_r.ctl[7:4] == 4'h0 && !mod_stretched) |=> (mod_stretched == $past(internal_envelope));
  endproperty
  a_src_env: assert property (p_src_env) else $error("envelope source not followed"); // see R11

  property p_src_ext;
    @(posedge clock) disable iff (rst)
      (s_r.ctl[1:0] == 2'b10 && s_r.ctl[7:4] == 4'h0 && !mod_stretched) |=>
        (mod_stretched == $past(external_signal_input));
  endproperty
  a_src_ext: assert property (p_src_ext) else $error("external source not followed"); // see R11

  property p_src_reserved;
    @(posedge clock) disable iff (rst)
      (s_r.ctl[1:0] == 2'b11 && s_r.ctl[7:4] == 4'h0 && !mod_stretched) |=> !mod_stretched;
  endproperty
  a_src_reserved: assert property (p_src_reserved) else $error("reserved source modulates"); // see R11

  property p_amp_reserved;
    @(posedge clock) disable iff (rst)
      (rd && addr == RFTX_ADDR_AMPLITUDE) |=> !rdata[5];
  endproperty
  a_amp_reserved: assert property (p_amp_reserved) else $error("amplitude reserved bit reads nonzero"); // see R12

  property p_mode_store;
    @(posedge clock) disable iff (rst)
      (wr && addr == RFTX_ADDR_DRIVER_MODE) |=> (s_r.mode == {$past(wdata[7:6]), 2'b00, $past(wdata[3:0])});
  endproperty
  a_mode_store: assert property (p_mode_store) else $error("driver mode write stored wrongly"); // see R12

  property p_amp_store;
    @(posedge clock) disable iff (rst)
      (wr && addr == RFTX_ADDR_AMPLITUDE) |=> (s_r.amp == {$past(wdata[7:6]), 1'b0, $past(wdata[4:0])});
  endproperty
  a_amp_store: assert property (p_amp_store) else $error("amplitude write stored wrongly"); // see R12

  property p_stretch_quiet;
    @(posedge clock) disable iff (rst)
      (!mod_stretched && !mod_sel) |=> !mod_stretched;
  endproperty
  a_stretch_quiet: assert property (p_stretch_quiet) else $error("stretch started without a fall"); // see R9

  property p_stretch_follow;
    @(posedge clock) disable iff (rst)
      mod_sel |=> mod_stretched;
  endproperty
  a_stretch_follow: assert property (p_stretch_follow) else $error("active modulation not passed on"); // see R9

  c_push_pull: cover property (@(posedge clock) s_r.mode[3] && s_r.mode[2:0] == 3'b001 && modulation_active);
  c_open_drain: cover property (@(posedge clock) s_r.mode[3] && s_r.mode[2:0] == 3'b000);
  c_full_level: cover property (@(posedge clock) carrier_full_level);
  c_stretch: cover property (@(posedge clock) mod_stretched && !mod_sel);

endmodule

/* rftx_pkg.sv */
// Package with register map, field layout and types of the transmitter driver configuration bank.
package rftx_pkg;

  localparam logic [7:0] RFTX_ADDR_DRIVER_MODE = 8'h28;
  localparam logic [7:0] RFTX_ADDR_AMPLITUDE = 8'h29;
  localparam logic [7:0] RFTX_ADDR_MODULATION = 8'h2a;

  localparam int RFTX_BIT_INV_TWO = 7;
  localparam int RFTX_BIT_INV_ONE = 6;
  localparam int RFTX_BIT_DRIVERS_ON = 3;
  localparam int RFTX_BIT_FULL_LEVEL = 3;
  localparam int RFTX_BIT_MOD_INVERT = 2;

  localparam logic [7:0] RFTX_MASK_DRIVER_MODE = 8'hcf;
  localparam logic [7:0] RFTX_MASK_AMPLITUDE = 8'hdf;
  localparam logic [7:0] RFTX_MASK_MODULATION = 8'hff;

  localparam logic [7:0] RFTX_RST_DRIVER_MODE = 8'h00;
  localparam logic [7:0] RFTX_RST_AMPLITUDE = 8'h00;
  localparam logic [7:0] RFTX_RST_MODULATION = 8'h00;

  // Carrier level drop in millivolts below the transmitter supply, per code.
  localparam logic [9:0] RFTX_DROP_MV_0 = 10'h064;
  localparam logic [9:0] RFTX_DROP_MV_1 = 10'h0fa;
  localparam logic [9:0] RFTX_DROP_MV_2 = 10'h1f4;
  localparam logic [9:0] RFTX_DROP_MV_3 = 10'h3e8;
  localparam logic [9:0] RFTX_DROP_MV_NONE = 10'h000;

  typedef enum logic [2:0] {
    RFTX_STY_OPEN_DRAIN = 3'b000,
    RFTX_STY_PUSH_PULL = 3'b001,
    RFTX_STY_HIGH_Z = 3'b010,
    RFTX_STY_BAD_A = 3'b011,
    RFTX_STY_FORCE_HIGH = 3'b100,
    RFTX_STY_FORCE_LOW = 3'b101,
    RFTX_STY_BAD_B = 3'b110,
    RFTX_STY_RESERVED = 3'b111
  } rftx_style_t;

  typedef enum logic [1:0] {
    RFTX_SRC_NONE = 2'b00,
    RFTX_SRC_ENVELOPE = 2'b01,
    RFTX_SRC_EXTERNAL = 2'b10,
    RFTX_SRC_RESERVED = 2'b11
  } rftx_src_t;

  typedef enum logic [1:0] {
    RFTX_OVS_IDLE = 2'b00,
    RFTX_OVS_RUN = 2'b01
  } rftx_ovs_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rftx_bus_t;

  // Pin drive pair: level and output enable, the enable low while driving.
  typedef struct packed {
    logic level;
    logic oe_n;
  } rftx_pin_t;

endpackage

/* rftx_overshoot.sv */
// Overshoot-prevention stretcher: extends modulation by a count of carrier clocks.
`timescale 1ns/1ps
module rftx_overshoot
  import rftx_pkg::*;
#(
  parameter int LEN_W = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic carrier_tick,
  input wire logic mod_in,
  input wire logic [LEN_W-1:0] overshoot_length,
  output logic mod_out
);

  typedef struct packed {
    rftx_ovs_state_t st;
    logic [LEN_W-1:0] cnt;
    logic prev;
    logic out;
  } rftx_ovs_t;

  rftx_ovs_t s_r;
  rftx_ovs_t s_nxt;

  // =====================================================================
  // Stretcher
  // After modulation ends, it is held for overshoot_length carrier clocks.
  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = mod_in;
    unique case (s_r.st)
      RFTX_OVS_IDLE: begin
        s_nxt.out = mod_in;
        if (s_r.prev && !mod_in && overshoot_length != '0) begin // see R9
          s_nxt.st = RFTX_OVS_RUN;
          s_nxt.cnt = overshoot_length;
          s_nxt.out = 1'b1;
        end
      end
      RFTX_OVS_RUN: begin
        s_nxt.out = 1'b1;
        if (mod_in) begin
          s_nxt.st = RFTX_OVS_IDLE;
        end else if (carrier_tick) begin
          s_nxt.cnt = s_r.cnt - 1'b1;
          if (s_r.cnt == {{(LEN_W-1){1'b0}}, 1'b1}) begin // see R9
            s_nxt.st = RFTX_OVS_IDLE;
            s_nxt.out = 1'b0;
          end
        end
      end
      default: begin
        s_nxt.st = RFTX_OVS_IDLE;
        s_nxt.out = mod_in;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '{st: RFTX_OVS_IDLE, cnt: '0, prev: 1'b0, out: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mod_out = s_r.out;

endmodule

/* rftx_antenna_model.sv */
// Behavioural antenna network loading the two transmitter driver pins.
`timescale 1ns/1ps
module rftx_antenna_model (
  input wire logic clock,
  input wire logic pin_one_level,
  input wire logic pin_one_oe_n,
  input wire logic pin_two_level,
  input wire logic pin_two_oe_n,
  output logic field_one,
  output logic field_two
);
  // The net has no pull, so a released pin shows a level that flips every cycle.
  logic float_r;
  initial float_r = 1'b0;
  always @(posedge clock) float_r <= ~float_r;
  assign field_one = pin_one_oe_n ? float_r : pin_one_level;
  assign field_two = pin_two_oe_n ? ~float_r : pin_two_level;
endmodule

/* rf_transmitter_driver_config_test.sv */
// Self-checking testbench of the transmitter driver configuration bank.
`timescale 1ns/1ps
module rf_transmitter_driver_config_test;
  import rftx_pkg::*;
  logic clock, rst, wr, rd, carrier_tick, internal_envelope, external_signal_input;
  logic [7:0] addr, wdata, rdata, d;
  logic p1, p1_oe_n, p2, p2_oe_n, full, act, f1, f2, rd_seen, m;
  logic [9:0] drop_mv;
  logic [4:0] resid;
  logic [11:0] t;
  logic [7:0] rd_q[$];
  int error_cnt, check_count;
  localparam logic [9:0] DROP [4] = '{10'h064, 10'h0fa, 10'h1f4, 10'h3e8};
  localparam logic [11:0] STY [6] = '{12'h1a0, 12'h3f0, 12'h555, 12'h9fa, 12'hbf0, 12'h255};
  rftx_driver_config i_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .carrier_tick(carrier_tick), .internal_envelope(internal_envelope),
    .external_signal_input(external_signal_input), .driver_pin_one_out(p1), .driver_pin_one_oe_n(p1_oe_n),
    .driver_pin_two_out(p2), .driver_pin_two_oe_n(p2_oe_n), .carrier_level_drop_mv(drop_mv),
    .carrier_full_level(full), .residual_carrier(resid), .modulation_active(act));
  rftx_antenna_model i_ant (.clock(clock), .pin_one_level(p1), .pin_one_oe_n(p1_oe_n),
    .pin_two_level(p2), .pin_two_oe_n(p2_oe_n), .field_one(f1), .field_two(f2));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ==========================================
  // Compare and bus tasks
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected read at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_out(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected output at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (rd_q.size() != 0) error_cnt++;
    $display("comparisons %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    rd_q.push_back(exp);
    @(posedge clock);
    rd <= 1'b0;
  endtask
  task automatic settle;
    repeat (4) @(posedge clock);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      carrier_tick <= 1'b1;
      @(posedge clock);
      carrier_tick <= 1'b0;
    end
  endtask
  function automatic logic [7:0] mask_of(input logic [7:0] a);
    return a == 8'h28 ? 8'hcf : a == 8'h29 ? 8'hdf : a == 8'h2a ? 8'hff : 8'h00;
  endfunction
  // ==========================================
  // Read data monitor
  always @(posedge clock) rd_seen <= rd;
  always @(negedge clock) begin
    if (rd_seen === 1'b1 && rd_q.size() > 0) begin
      cmp_byte(rdata, rd_q.pop_front());
    end
  end
  // ==========================================
  // Tests
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    carrier_tick = 1'b0;
    internal_envelope = 1'b0;
    external_signal_input = 1'b0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    d = 8'($urandom(32'h1a81));
    for (int i = 0; i < 4; i++) rd_reg(8'h28 + 8'(i), 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom());
      if (d[2:0] == 3'b011 || d[2:0] == 3'b110) d[2:0] = 3'b001;
      wr_reg(8'h28 + 8'(i % 4), d);
      rd_reg(8'h28 + 8'(i % 4), mask_of(8'h28 + 8'(i % 4)) & d);
    end
    $display("test register access done");
    for (int c = 0; c < 8; c++) begin
      d = {3'(c), 5'($urandom())};
      wr_reg(8'h29, {d[6:5], 1'b1, d[4:0]});
      wr_reg(8'h2a, {4'h0, d[7], 3'h0});
      settle();
      cmp_out(drop_mv, d[7] ? 10'h000 : DROP[d[6:5]]);
      cmp_out({5'h00, resid}, {5'h00, d[4:0]});
      cmp_out({9'h000, full}, {9'h000, d[7]});
    end
    $display("test amplitude done");
    for (int k = 0; k < 32; k++) begin
      d = 8'(k);
      internal_envelope <= 1'($urandom());
      external_signal_input <= 1'($urandom());
      wr_reg(8'h28, {d[4], d[3], 6'h09});
      wr_reg(8'h2a, {5'h00, d[2:0]});
      settle();
      m = (d[1:0] == 2'b01 ? internal_envelope : d[1:0] == 2'b10 ? external_signal_input : 1'b0) ^ d[2];
      cmp_out({9'h000, act}, {9'h000, m});
      cmp_out({6'h00, p1, p1_oe_n, p2, p2_oe_n}, {6'h00, m ^ d[3], 1'b0, m ^ d[4], 1'b0});
      cmp_out({8'h00, f1, f2}, {8'h00, m ^ d[3], m ^ d[4]});
    end
    $display("test modulation source done");
    for (int k = 0; k < 6; k++) begin
      t = STY[k];
      wr_reg(8'h28, {4'h0, t[8], t[11:9]});
      wr_reg(8'h2a, 8'h00);
      settle();
      cmp_out({6'h00, {p1, p1_oe_n, p2, p2_oe_n} & t[7:4]}, {6'h00, t[3:0]});
    end
    $display("test output style done");
    wr_reg(8'h28, 8'h09);
    wr_reg(8'h2a, 8'h31);
    internal_envelope <= 1'b1;
    settle();
    internal_envelope <= 1'b0;
    settle();
    cmp_out({9'h000, act}, 10'h001);
    tick(2);
    settle();
    cmp_out({8'h00, act, p1}, 10'h003);
    tick(2);
    settle();
    cmp_out({8'h00, act, p1}, 10'h000);
    $display("test overshoot length done");
    settle();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    close_out();
  end
endmodule
